// ### rtl/meab_alu.sv
// adder and logic unit with carry, half carry and zero outputs
`timescale 1ns/10ps
`include "meab_consts.svh"
module meab_alu
  import meab_pkg::*;
(
  input  wire logic [7:0] a_in,
  input  wire logic [7:0] b_in,
  input  wire logic       do_and_in,
  output logic      [7:0] res_out,
  output logic            carry_out,
  output logic            half_carry_out,
  output logic            zero_out
);
  wire logic [8:0] sum_w;
  wire logic [4:0] low_w;
  assign sum_w          = {1'b0, a_in} + {1'b0, b_in};
  assign low_w          = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
  assign res_out        = do_and_in ? (a_in & b_in) : sum_w[7:0];
  assign carry_out      = sum_w[8];
  assign half_carry_out = low_w[4];
  assign zero_out       = (res_out == 8'h00);
endmodule : meab_alu

// ### rtl/meab_consts.svh
// constants for the execution datapath block
`ifndef MEAB_CONSTS_SVH
`define MEAB_CONSTS_SVH
`define MEAB_DATA_W      8
`define MEAB_PC_W        9
`define MEAB_ADDR_W      6
`define MEAB_BIT_W       3
`define MEAB_STACK_DEPTH 2
`define MEAB_ACC_RST     8'h00
`define MEAB_PC_RST      9'h000
`define MEAB_FLAG_C      0
`define MEAB_FLAG_HALF_CARRY 1
`define MEAB_FLAG_Z      2
`define MEAB_FLAGS_RST   3'h0
`define MEAB_BRANCH_CYC  2
`endif

// ### rtl/meab_exec.sv
// execution datapath: arithmetic, bit clear, call, jump and literal return
// Functional notes
// - return-with-literal loads literal to accumulator, pops stack into pc, two cycles.
// - call pushes next address, loads 9-bit literal into pc, two cycles.
// - register field is 6 bits, bit field selects one of eight bits.
// - destination bit zero writes accumulator, one writes file register.
// - add register sums operands, writes destination, updates carry, half carry, zero, one cycle.
// - add literal sums accumulator and literal into accumulator, updates carry, half carry, zero.
// - and register writes and to destination, updates only z, one cycle.
// - and literal writes and to accumulator, updates only z.
// - bit clear zeroes chosen bit, keeps others and flags, one cycle.
`timescale 1ns/10ps
`include "meab_consts.svh"
module meab_exec
  import meab_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire logic                      reset_in,
  input  wire logic                      instr_valid_in,
  input  wire meab_op_e                  op_in,
  input  wire logic [`MEAB_PC_W-1:0]     literal_in,
  input  wire logic [`MEAB_ADDR_W-1:0]   reg_addr_in,
  input  wire logic [`MEAB_BIT_W-1:0]    bit_sel_in,
  input  wire logic                      dest_in,
  input  wire logic [`MEAB_DATA_W-1:0]   file_rdata_in,
  output logic [`MEAB_ADDR_W-1:0]        file_addr_out,
  output logic                           file_we_out,
  output logic [`MEAB_DATA_W-1:0]        file_wdata_out,
  output logic [`MEAB_DATA_W-1:0]        acc_out,
  output logic                           carry_out,
  output logic                           half_carry_flag_out,
  output logic                           zero_out,
  output logic [`MEAB_PC_W-1:0]          pc_out,
  output logic                           busy_out
);
  meab_state_e                state_q, state_d;
  logic [`MEAB_DATA_W-1:0]    acc_q, acc_d;
  logic [`MEAB_PC_W-1:0]      pc_q, pc_d;
  logic [2:0]                 flags_q, flags_d;
  logic [`MEAB_PC_W-1:0]      stack_q [`MEAB_STACK_DEPTH];
  logic [`MEAB_ADDR_W-1:0]    faddr_q;
  logic                       fwe_q;
  logic [`MEAB_DATA_W-1:0]    fwdata_q;

  wire logic                  take_w;
  wire logic                  is_add_w;
  wire logic                  is_and_w;
  wire logic                  lit_op_w;
  wire logic                  reg_op_w;
  wire logic                  branch_w;
  wire logic [7:0]            b_opnd_w;
  wire logic [7:0]            alu_res_w;
  wire logic                  alu_c_w;
  wire logic                  alu_hc_w;
  wire logic                  alu_z_w;
  wire logic [7:0]            clr_res_w;
  wire logic                  to_file_w;
  wire logic                  to_acc_w;

  // the fetch stage must hold off while busy: the instruction after a branch is discarded
  assign take_w    = instr_valid_in && (state_q == MEAB_ST_EXEC);
  assign is_add_w  = (op_in == MEAB_OP_ADD_ACC_REG) || (op_in == MEAB_OP_ADD_ACC_LITERAL);
  assign is_and_w  = (op_in == MEAB_OP_AND_ACC_REG) || (op_in == MEAB_OP_AND_ACC_LITERAL);
  assign lit_op_w  = (op_in == MEAB_OP_ADD_ACC_LITERAL) || (op_in == MEAB_OP_AND_ACC_LITERAL);
  assign reg_op_w  = (op_in == MEAB_OP_ADD_ACC_REG) || (op_in == MEAB_OP_AND_ACC_REG);
  assign branch_w  = (op_in == MEAB_OP_CALL) || (op_in == MEAB_OP_JUMP)
                  || (op_in == MEAB_OP_RETURN_WITH_LITERAL);
  assign b_opnd_w  = lit_op_w ? literal_in[7:0] : file_rdata_in;
  assign clr_res_w = file_rdata_in & ~(8'h01 << bit_sel_in);
  assign to_file_w = take_w && ((reg_op_w && dest_in) || op_in == MEAB_OP_BIT_CLEAR_REG);
  assign to_acc_w  = take_w && ((reg_op_w && !dest_in) || lit_op_w);

  meab_alu u_alu (
    .a_in           (acc_q),
    .b_in           (b_opnd_w),
    .do_and_in      (is_and_w),
    .res_out        (alu_res_w),
    .carry_out      (alu_c_w),
    .half_carry_out (alu_hc_w),
    .zero_out       (alu_z_w)
  );

  always_comb begin
    state_d = MEAB_ST_EXEC;
    acc_d   = acc_q;
    pc_d    = pc_q;
    flags_d = flags_q;
    if (take_w) begin
      pc_d = pc_q + 9'h001;
      if (to_acc_w) begin
        acc_d = alu_res_w;
      end
      if (is_add_w) begin
        flags_d = {alu_z_w, alu_hc_w, alu_c_w};
      end else if (is_and_w) begin
        flags_d[`MEAB_FLAG_Z] = alu_z_w;
      end
      unique case (op_in)
        MEAB_OP_RETURN_WITH_LITERAL: begin
          acc_d = literal_in[7:0];
          pc_d  = stack_q[0];
        end
        MEAB_OP_CALL: pc_d = literal_in;
        MEAB_OP_JUMP: pc_d = literal_in;
        default: ;
      endcase
      if (branch_w) begin
        state_d = MEAB_ST_FLUSH;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= MEAB_ST_EXEC;
      acc_q   <= `MEAB_ACC_RST;
      pc_q    <= `MEAB_PC_RST;
      flags_q <= `MEAB_FLAGS_RST;
    end else begin
      state_q <= state_d;
      acc_q   <= acc_d;
      pc_q    <= pc_d;
      flags_q <= flags_d;
    end
  end

  // two-level stack: push shifts down, pop shifts up; jump leaves it alone
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stack_q[0] <= `MEAB_PC_RST;
      stack_q[1] <= `MEAB_PC_RST;
    end else if (take_w && op_in == MEAB_OP_CALL) begin
      stack_q[0] <= pc_q + 9'h001;
      stack_q[1] <= stack_q[0];
    end else if (take_w && op_in == MEAB_OP_RETURN_WITH_LITERAL) begin
      stack_q[0] <= stack_q[1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fwe_q    <= 1'b0;
      faddr_q  <= 6'h00;
      fwdata_q <= 8'h00;
    end else begin
      fwe_q    <= to_file_w;
      faddr_q  <= reg_addr_in;
      fwdata_q <= (op_in == MEAB_OP_BIT_CLEAR_REG) ? clr_res_w : alu_res_w;
    end
  end

  // limitation: the write-back address shows only while no new instruction is taken,
  // so the fetch stage keeps the cycle after a file write free
  assign file_addr_out       = take_w ? reg_addr_in : faddr_q;
  assign file_we_out         = fwe_q;
  assign file_wdata_out      = fwdata_q;
  assign acc_out             = acc_q;
  assign carry_out           = flags_q[`MEAB_FLAG_C];
  assign half_carry_flag_out = flags_q[`MEAB_FLAG_HALF_CARRY];
  assign zero_out            = flags_q[`MEAB_FLAG_Z];
  assign pc_out              = pc_q;
  assign busy_out            = (state_q == MEAB_ST_FLUSH);

  // a taken branch leaves exactly one dead fetch slot behind it
  sequence meab_flush_s;
    busy_out ##1 !busy_out;
  endsequence
  chk_branch_two_cycles: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && branch_w |=> meab_flush_s) else $error("branch not two cycles");
  chk_call_push: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_CALL |=> stack_q[0] == $past(pc_q) + 9'h001 && pc_q == $past(literal_in))
    else $error("call push or target wrong");
  chk_return_pop: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_RETURN_WITH_LITERAL |=> pc_q == $past(stack_q[0])
    && acc_q == $past(literal_in[7:0])) else $error("return wrong");
  chk_jump_stack: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_JUMP |=> $stable(stack_q[0]) && pc_q == $past(literal_in))
    else $error("jump wrong");
  chk_dest_file: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && reg_op_w && dest_in |=> file_we_out && $stable(acc_q)) else $error("dest file wrong");
  chk_add_flags: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_ADD_ACC_LITERAL |=> carry_out == (({1'b0, $past(acc_q)}
    + {1'b0, $past(literal_in[7:0])}) > 9'h0ff) && acc_q == $past(acc_q) + $past(literal_in[7:0]))
    else $error("add result or carry wrong");
  chk_and_flags: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && is_and_w |=> $stable(carry_out) && $stable(half_carry_flag_out)
    && zero_out == ($past(alu_res_w) == 8'h00)) else $error("and flags wrong");
  chk_bit_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_BIT_CLEAR_REG |=> file_we_out && !file_wdata_out[$past(bit_sel_in)]
    && $stable(flags_q)) else $error("bit clear wrong");
  // arithmetic below is rebuilt from the operands, not taken from the adder
  chk_busy_refuse: assert property (@(posedge clk_in) disable iff (reset_in)
    busy_out |=> $stable(acc_q) && $stable(pc_q) && $stable(flags_q) && !file_we_out)
    else $error("fetch taken while busy");
  chk_add_reg_half: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_ADD_ACC_REG |=> half_carry_flag_out
    == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(file_rdata_in[3:0])}) > 5'h0f)
    && carry_out == (({1'b0, $past(acc_q)} + {1'b0, $past(file_rdata_in)}) > 9'h0ff)
    && zero_out == (($past(acc_q) + $past(file_rdata_in)) == 8'h00)) else $error("add register flags wrong");
  chk_lit_half: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_ADD_ACC_LITERAL |=> half_carry_flag_out
    == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(literal_in[3:0])}) > 5'h0f)
    && zero_out == (($past(acc_q) + $past(literal_in[7:0])) == 8'h00)) else $error("add literal flags wrong");
  chk_reg_dest_acc: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && reg_op_w && !dest_in |=> !file_we_out) else $error("accumulator destination wrote file");
  chk_clear_keep: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_BIT_CLEAR_REG |=> (file_wdata_out | (8'h01 << $past(bit_sel_in)))
    == ($past(file_rdata_in) | (8'h01 << $past(bit_sel_in)))) else $error("bit clear disturbed other bits");
  chk_and_reg: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_AND_ACC_REG && !dest_in |=> acc_q == ($past(acc_q) & $past(file_rdata_in))
    && $stable(carry_out) && $stable(half_carry_flag_out)) else $error("and register result wrong");
  chk_add_reg_res: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && op_in == MEAB_OP_ADD_ACC_REG && dest_in |=> file_wdata_out == $past(acc_q) + $past(file_rdata_in)
    && $stable(acc_q)) else $error("add register write-back wrong");
  chk_branch_flags: assert property (@(posedge clk_in) disable iff (reset_in)
    take_w && branch_w |=> $stable(flags_q) && !file_we_out) else $error("branch touched flags or file");
  // no disable here: this one watches the reset itself
  chk_reset_state: assert property (@(posedge clk_in) reset_in |=> acc_q == `MEAB_ACC_RST
    && pc_q == `MEAB_PC_RST && stack_q[0] == `MEAB_PC_RST && !busy_out && !file_we_out)
    else $error("reset state wrong");
endmodule : meab_exec

// ### rtl/meab_pkg.sv
// types for the execution datapath block
package meab_pkg;
  typedef enum logic [3:0] {
    MEAB_OP_NOP,
    MEAB_OP_ADD_ACC_REG,
    MEAB_OP_ADD_ACC_LITERAL,
    MEAB_OP_AND_ACC_REG,
    MEAB_OP_AND_ACC_LITERAL,
    MEAB_OP_BIT_CLEAR_REG,
    MEAB_OP_RETURN_WITH_LITERAL,
    MEAB_OP_CALL,
    MEAB_OP_JUMP
  } meab_op_e;
  typedef enum logic {
    MEAB_ST_EXEC,
    MEAB_ST_FLUSH
  } meab_state_e;
endpackage : meab_pkg

// ### verification/mcu_exec_arith_branch_test.sv
// self-checking bench for the execution datapath
`timescale 1ns/10ps
module mcu_exec_arith_branch_test;
  import meab_pkg::*;
  logic clk_in, reset_in, instr_valid_in, dest_in, file_we_out, carry_out, half_carry_flag_out, zero_out, busy_out;
  meab_op_e op_in;
  logic [8:0] literal_in, pc_out;
  logic [5:0] reg_addr_in, file_addr_out;
  logic [2:0] bit_sel_in;
  logic [7:0] file_rdata_in, file_wdata_out, acc_out;
  int miscompares = 0;
  int check_count = 0;
  meab_exec meab_exec_i (.clk_in, .reset_in, .instr_valid_in, .op_in, .literal_in, .reg_addr_in, .bit_sel_in,
    .dest_in, .file_rdata_in, .file_addr_out, .file_we_out, .file_wdata_out, .acc_out, .carry_out,
    .half_carry_flag_out, .zero_out, .pc_out, .busy_out);
  meab_file_model meab_file_model_i (.clk_in, .addr_in(file_addr_out), .we_in(file_we_out),
    .wdata_in(file_wdata_out), .rdata_out(file_rdata_in));
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // every task starts and ends 1 ns after a rising edge
  // run leaves valid up, so back-to-back requests never drive it twice in one step
  task automatic run(input meab_op_e o, input logic [8:0] l, input logic [5:0] a, input logic [2:0] b,
                     input logic d);
    op_in = o;
    literal_in = l;
    reg_addr_in = a;
    bit_sel_in = b;
    dest_in = d;
    instr_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
  endtask : run
  task automatic st(input logic [7:0] a, input logic [2:0] f, input logic [8:0] p);
    chk("acc", acc_out, a);
    chk("flags", {carry_out, half_carry_flag_out, zero_out}, f);
    chk("pc", pc_out, p);
  endtask : st
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    instr_valid_in = 1'b0;
    #1 chk("we", file_we_out, 1'b1);
    chk("faddr", file_addr_out, a);
    chk("wdata", file_wdata_out, v);
    @(posedge clk_in);
    #1 chk("we_end", file_we_out, 1'b0);
  endtask : wr
  // busy lasts one cycle; busy still high after four more cycles is a fault
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_out !== 1'b0) begin
      if (n++ == 4) begin
        miscompares++;
        test_done();
      end
      @(posedge clk_in);
      #1;
    end
  endtask : wait_idle
  task automatic t_arith();
    run(MEAB_OP_ADD_ACC_LITERAL, 9'h08f, 6'h00, 3'h0, 1'b0);
    st(8'h8f, 3'b000, 9'h001);
    run(MEAB_OP_ADD_ACC_REG, 9'h000, 6'h3f, 3'h0, 1'b1);
    st(8'h8f, 3'b111, 9'h002);
    wr(6'h3f, 8'h00);
    run(MEAB_OP_AND_ACC_LITERAL, 9'h0f0, 6'h00, 3'h0, 1'b0);
    st(8'h80, 3'b110, 9'h003);
    run(MEAB_OP_ADD_ACC_REG, 9'h000, 6'h00, 3'h0, 1'b0);
    st(8'h81, 3'b000, 9'h004);
    chk("we_acc", file_we_out, 1'b0);
    run(MEAB_OP_AND_ACC_REG, 9'h000, 6'h01, 3'h0, 1'b1);
    st(8'h81, 3'b001, 9'h005);
    wr(6'h01, 8'h00);
  endtask : t_arith
  task automatic t_bitclr();
    run(MEAB_OP_BIT_CLEAR_REG, 9'h000, 6'h02, 3'h7, 1'b0);
    st(8'h81, 3'b001, 9'h006);
    wr(6'h02, 8'h7f);
  endtask : t_bitclr
  task automatic t_branch();
    run(MEAB_OP_CALL, 9'h1a5, 6'h00, 3'h0, 1'b0);
    st(8'h81, 3'b001, 9'h1a5);
    chk("busy", busy_out, 1'b1);
    run(MEAB_OP_JUMP, 9'h0ff, 6'h00, 3'h0, 1'b0);
    chk("pc_refused", pc_out, 9'h1a5);
    chk("busy_end", busy_out, 1'b0);
    run(MEAB_OP_RETURN_WITH_LITERAL, 9'h05a, 6'h00, 3'h0, 1'b0);
    st(8'h5a, 3'b001, 9'h007);
    chk("busy_ret", busy_out, 1'b1);
    wait_idle();
    run(MEAB_OP_JUMP, 9'h133, 6'h00, 3'h0, 1'b0);
    st(8'h5a, 3'b001, 9'h133);
    chk("busy_jmp", busy_out, 1'b1);
    wait_idle();
    run(MEAB_OP_CALL, 9'h010, 6'h00, 3'h0, 1'b0);
    wait_idle();
    run(MEAB_OP_JUMP, 9'h020, 6'h00, 3'h0, 1'b0);
    wait_idle();
    run(MEAB_OP_RETURN_WITH_LITERAL, 9'h0c3, 6'h00, 3'h0, 1'b0);
    st(8'hc3, 3'b001, 9'h134);
  endtask : t_branch
  task automatic t_flags();
    wait_idle();
    run(MEAB_OP_ADD_ACC_LITERAL, 9'h00d, 6'h00, 3'h0, 1'b0);
    st(8'hd0, 3'b010, 9'h135);
    run(MEAB_OP_ADD_ACC_LITERAL, 9'h040, 6'h00, 3'h0, 1'b0);
    st(8'h10, 3'b100, 9'h136);
    run(MEAB_OP_AND_ACC_REG, 9'h000, 6'h00, 3'h0, 1'b0);
    st(8'h00, 3'b101, 9'h137);
    chk("we_and", file_we_out, 1'b0);
  endtask : t_flags
  // reset while a branch is still flushing, then check the stack came back empty
  task automatic t_reset();
    run(MEAB_OP_CALL, 9'h0aa, 6'h00, 3'h0, 1'b0);
    st(8'h00, 3'b101, 9'h0aa);
    instr_valid_in = 1'b0;
    reset_in = 1'b1;
    @(posedge clk_in);
    #1 reset_in = 1'b0;
    st(8'h00, 3'b000, 9'h000);
    chk("busy_rst", busy_out, 1'b0);
    chk("we_rst", file_we_out, 1'b0);
    run(MEAB_OP_RETURN_WITH_LITERAL, 9'h011, 6'h00, 3'h0, 1'b0);
    st(8'h11, 3'b000, 9'h000);
    chk("busy_rst_ret", busy_out, 1'b1);
    wait_idle();
  endtask : t_reset
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    reset_in = 1'b1;
    instr_valid_in = 1'b0;
    op_in = MEAB_OP_NOP;
    literal_in = 9'h000;
    reg_addr_in = 6'h00;
    bit_sel_in = 3'h0;
    dest_in = 1'b0;
    meab_file_model_i.mem_q[63] = 8'h71;
    meab_file_model_i.mem_q[0] = 8'h01;
    meab_file_model_i.mem_q[1] = 8'h7e;
    meab_file_model_i.mem_q[2] = 8'hff;
    repeat (6) @(posedge clk_in);
    #1 reset_in = 1'b0;
    st(8'h00, 3'b000, 9'h000);
    t_arith();
    t_bitclr();
    t_branch();
    t_flags();
    t_reset();
    test_done();
  end
endmodule : mcu_exec_arith_branch_test

// ### verification/meab_file_model.sv
// data register file model facing the execution datapath
`timescale 1ns/10ps
module meab_file_model (
  input  wire logic       clk_in,
  input  wire logic [5:0] addr_in,
  input  wire logic       we_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem_q [64];
  // read is combinational: the block samples it in the taking cycle
  assign rdata_out = mem_q[addr_in];
  // plain always so the bench may preload cells
  always @(posedge clk_in) begin
    if (we_in) begin
      mem_q[addr_in] <= wdata_in;
    end
  end
endmodule : meab_file_model
